// *** core/subexec_core.sv ***
// Purpose: Execution datapath for subtract-from-immediate and subtract-from-file
// Assumes: APB slave, zero wait states, clk_i at 10 MHz, ce_i high during APB traffic
// Notes:   One instruction word per write to the instruction register
//
// How it works
// RL1 - Immediate minus working register lands in working register
// RL2 - Immediate read in second quarter, processed in third quarter
// RL3 - File minus working register goes to working register or file by destination bit
// RL4 - Access bit 0 uses access bank, 1 uses bank select register
// RL5 - Extended set, access 0, address up to 95: indexed literal-offset addressing
// RL6 - File subtract updates negative, overflow, carry, digit carry, zero
// RL7 - Borrow clears carry, clears zero, negative copies result bit 7, two's complement result
// RL8 - One word, one instruction cycle, destination written in fourth quarter
`timescale 1ns/1ps
`default_nettype none
`include "subexec_consts.svh"

module subexec_core
    import subexec_pkg::*;
#(
    parameter int PADDR_W = 16
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               ce_i,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [PADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic                    busy_o
);

    // ==========================================================
    // Elaboration check
    // Window decode needs address bits 15:14
    if (PADDR_W < 16) begin : g_paddr_check
        $error("PADDR_W must be at least 16");
    end

    // ==========================================================
    // Helpers
    // Data address from file field, access bit and bank state
    function automatic logic [11:0] eff_addr(input logic [7:0]  f,
                                             input logic        a,
                                             input logic        ext,
                                             input logic [3:0]  bank,
                                             input logic [11:0] base);
        if (a) begin
            eff_addr = {bank, f};                                     // see RL4
        end else if (ext && (f <= `INDEXED_LIMIT)) begin
            eff_addr = 12'(base + {4'h0, f});                         // see RL5
        end else if (f < `ACCESS_SPLIT) begin
            eff_addr = {4'h0, f};                                     // see RL4
        end else begin
            eff_addr = {`ACCESS_HI_BANK, f};
        end
    endfunction

    function automatic logic is_imm(input logic [15:0] w);
        is_imm = (w[15:8] == `OPC_IMM);
    endfunction

    function automatic logic is_file(input logic [15:0] w);
        is_file = (w[15:10] == `OPC_FILE);
    endfunction

    // ==========================================================
    // State and memory
    state_t      st;
    state_t      next_st;
    logic [7:0]  dmem [0:4095];
    logic [7:0]  diff;
    logic [4:0]  dflags;
    logic        mem_we;
    logic [11:0] mem_wa;
    logic [7:0]  mem_wd;
    logic [11:0] ia_addr;
    logic        setup;
    logic        wr_acc;
    logic        in_win;
    logic [15:0] ofs;
    logic        mapped;
    logic        busy;

    sub_flags i_sub_flags (
        .minuend_i    (st.operand),
        .subtrahend_i (st.wreg),
        .diff_o       (diff),
        .flags_o      (dflags)
    );

    assign busy    = (st.phase != PH_IDLE);
    assign ia_addr = eff_addr(st.instr[7:0], st.instr[`INSTR_A_BIT], st.ext_en,
                              st.bank_sel, st.index_base);
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && !st.pslverr;
    assign ofs     = paddr[15:0];
    assign in_win  = (ofs[15:14] == `DMEM_WIN_TAG) && (paddr[PADDR_W-1:14] ==
                     (PADDR_W-14)'(`DMEM_WIN_TAG));
    assign mapped  = in_win || (ofs == `OFS_CTRL) || (ofs == `OFS_WREG)
                     || (ofs == `OFS_STATUS) || (ofs == `OFS_BANK_SEL)
                     || (ofs == `OFS_INDEX_BASE) || (ofs == `OFS_INSTR);

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        mem_we  = 1'b0;
        mem_wa  = ofs[13:2];
        mem_wd  = pwdata[7:0];
        case (st.phase)
            PH_IDLE: begin
                next_st.phase = PH_IDLE;
            end
            PH_Q1: begin
                next_st.phase = PH_Q2;
                next_st.addr  = ia_addr;
            end
            PH_Q2: begin
                next_st.phase = PH_Q3;
                if (is_imm(st.instr)) begin
                    next_st.operand = st.instr[7:0];                  // see RL2
                end else begin
                    next_st.operand = dmem[st.addr];                  // see RL3
                end
            end
            PH_Q3: begin
                next_st.phase     = PH_Q4;
                next_st.result    = diff;                             // see RL1
                next_st.res_flags = dflags;                           // see RL6
            end
            PH_Q4: begin
                next_st.phase = PH_IDLE;
                next_st.flags = st.res_flags;                         // see RL7
                if (is_file(st.instr) && st.instr[`INSTR_D_BIT]) begin
                    mem_we = 1'b1;                                    // see RL8
                    mem_wa = st.addr;
                    mem_wd = st.result;
                end else begin
                    next_st.wreg = st.result;                         // see RL3
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase

        // Setup phase latches read data and the error answer
        if (setup) begin
            next_st.prdata  = 32'h0000_0000;
            next_st.pslverr = !mapped || (pwrite && busy)
                              || (pwrite && (ofs == `OFS_INSTR)
                                  && !is_imm(pwdata[15:0]) && !is_file(pwdata[15:0]));
            if (!pwrite) begin
                if (in_win) begin
                    next_st.prdata = {24'h00_0000, dmem[ofs[13:2]]};
                end else begin
                    case (ofs)
                        `OFS_CTRL:       next_st.prdata[`CTRL_EXT_BIT] = st.ext_en;
                        `OFS_WREG:       next_st.prdata[7:0] = st.wreg;
                        `OFS_STATUS:     next_st.prdata[4:0] = st.flags;
                        `OFS_BANK_SEL:   next_st.prdata[3:0] = st.bank_sel;
                        `OFS_INDEX_BASE: next_st.prdata[11:0] = st.index_base;
                        `OFS_INSTR: begin
                            next_st.prdata[15:0]            = st.instr;
                            next_st.prdata[`INSTR_BUSY_BIT] = busy;
                        end
                        default:         next_st.prdata = 32'h0000_0000;
                    endcase
                end
            end
        end

        // Writes are refused while busy, so they never race the datapath
        if (wr_acc) begin
            if (in_win) begin
                mem_we = 1'b1;
            end else begin
                case (ofs)
                    `OFS_CTRL:       next_st.ext_en = pwdata[`CTRL_EXT_BIT];
                    `OFS_WREG:       next_st.wreg = pwdata[7:0];
                    `OFS_STATUS:     next_st.flags = pwdata[4:0];
                    `OFS_BANK_SEL:   next_st.bank_sel = pwdata[3:0];
                    `OFS_INDEX_BASE: next_st.index_base = pwdata[11:0];
                    `OFS_INSTR: begin
                        next_st.instr = pwdata[15:0];                 // see RL8
                        next_st.phase = PH_Q1;
                    end
                    default:         next_st.ext_en = st.ext_en;
                endcase
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st            <= '0;
            st.phase      <= PH_IDLE;
            st.wreg       <= `RST_WREG;
            st.flags      <= `RST_FLAGS;
            st.bank_sel   <= `RST_BANK_SEL;
            st.index_base <= `RST_INDEX_BASE;
            st.instr      <= `RST_INSTR;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // No reset on the data memory: its contents are undefined at power-up
    always_ff @(posedge clk_i) begin
        if (ce_i && mem_we) begin
            dmem[mem_wa] <= mem_wd;
        end
    end

    assign prdata  = st.prdata;
    assign pslverr = st.pslverr && psel && penable;
    assign pready  = 1'b1;
    assign busy_o  = busy;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_imm_result;
        (st.phase == PH_Q3) && ce_i && is_imm(st.instr)
        |=> st.result == 8'($past(st.operand) - $past(st.wreg));
    endproperty
    a_imm_result: assert property (p_imm_result) // see RL1
        else $error("Immediate difference wrong");

    property p_imm_read_q2;
        (st.phase == PH_Q2) && ce_i && is_imm(st.instr)
        |=> (st.operand == st.instr[7:0]) && (st.phase == PH_Q3);
    endproperty
    a_imm_read_q2: assert property (p_imm_read_q2) // see RL2
        else $error("Immediate not read in second quarter");

    property p_file_dest;
        (st.phase == PH_Q4) && ce_i && is_file(st.instr) && !st.instr[`INSTR_D_BIT]
        |=> st.wreg == $past(st.result);
    endproperty
    a_file_dest: assert property (p_file_dest) // see RL3
        else $error("File result not in working register");

    property p_file_to_mem;
        (st.phase == PH_Q4) && ce_i && is_file(st.instr) && st.instr[`INSTR_D_BIT]
        |=> (dmem[$past(st.addr)] == $past(st.result)) && (st.wreg == $past(st.wreg));
    endproperty
    a_file_to_mem: assert property (p_file_to_mem) // see RL3
        else $error("File result not written back");

    property p_banked;
        (st.phase == PH_Q2) && is_file(st.instr) && st.instr[`INSTR_A_BIT]
        |-> st.addr == {st.bank_sel, st.instr[7:0]};
    endproperty
    a_banked: assert property (p_banked) // see RL4
        else $error("Bank select not used");

    property p_indexed;
        (st.phase == PH_Q2) && is_file(st.instr) && !st.instr[`INSTR_A_BIT]
        && st.ext_en && (st.instr[7:0] <= `INDEXED_LIMIT)
        |-> st.addr == 12'(st.index_base + {4'h0, st.instr[7:0]});
    endproperty
    a_indexed: assert property (p_indexed) // see RL5
        else $error("Indexed address wrong");

    property p_flags_zero;
        (st.phase == PH_Q4) && ce_i
        |=> st.flags[`FLAG_Z_BIT] == ($past(st.result) == 8'h00);
    endproperty
    a_flags_zero: assert property (p_flags_zero) // see RL6
        else $error("Zero flag wrong");

    property p_borrow;
        (st.phase == PH_Q4) && ce_i && !st.res_flags[`FLAG_C_BIT]
        |=> !st.flags[`FLAG_C_BIT] && !st.flags[`FLAG_Z_BIT]
            && (st.flags[`FLAG_N_BIT] == $past(st.result[7]));
    endproperty
    a_borrow: assert property (p_borrow) // see RL7
        else $error("Borrow flags wrong");

    property p_one_cycle;
        ((st.phase == PH_Q1) && ce_i) ##1 ce_i [*3]
        |=> st.phase == PH_IDLE;
    endproperty
    a_one_cycle: assert property (p_one_cycle) // see RL8
        else $error("Instruction not done in four quarters");

    c_imm:   cover property ((st.phase == PH_Q4) && ce_i && is_imm(st.instr));
    c_file:  cover property ((st.phase == PH_Q4) && ce_i && is_file(st.instr)
                             && st.instr[`INSTR_D_BIT]);
    c_index: cover property ((st.phase == PH_Q2) && st.ext_en && is_file(st.instr)
                             && !st.instr[`INSTR_A_BIT]);
    c_neg:   cover property ((st.phase == PH_Q4) && !st.res_flags[`FLAG_C_BIT]);

endmodule
`default_nettype wire

// *** core/subexec_consts.svh ***
// Purpose: Offsets, field positions, reset values and encodings for the subtract datapath
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   Included by the datapath, the flag subtractor and the bench
`ifndef SUBEXEC_CONSTS_SVH
`define SUBEXEC_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        16'h0000
`define OFS_WREG        16'h0004
`define OFS_STATUS      16'h0008
`define OFS_BANK_SEL    16'h000C
`define OFS_INDEX_BASE  16'h0010
`define OFS_INSTR       16'h0014
`define DMEM_WIN_TAG    2'h1

// ==========================================================
// Field positions
`define CTRL_EXT_BIT    0
`define FLAG_C_BIT      0
`define FLAG_DC_BIT     1
`define FLAG_Z_BIT      2
`define FLAG_OV_BIT     3
`define FLAG_N_BIT      4
`define INSTR_BUSY_BIT  16
`define INSTR_D_BIT     9
`define INSTR_A_BIT     8

// ==========================================================
// Reset values
`define RST_WREG        8'h00
`define RST_FLAGS       5'h00
`define RST_BANK_SEL    4'h0
`define RST_INDEX_BASE  12'h000
`define RST_INSTR       16'h0000

// ==========================================================
// Encodings and address map
`define OPC_IMM         8'h08
`define OPC_FILE        6'h17
`define ACCESS_SPLIT    8'h60
`define INDEXED_LIMIT   8'h5F
`define ACCESS_HI_BANK  4'hF

`endif

// *** core/subexec_pkg.sv ***
// Purpose: Types shared by the subtract datapath
// Assumes: Constants come from subexec_consts.svh
// Notes:   State is one packed struct
package subexec_pkg;

    typedef enum logic [4:0] {
        PH_IDLE = 5'h01,
        PH_Q1   = 5'h02,
        PH_Q2   = 5'h04,
        PH_Q3   = 5'h08,
        PH_Q4   = 5'h10
    } phase_t;

    typedef struct packed {
        phase_t       phase;
        logic         ext_en;
        logic [7:0]   wreg;
        logic [4:0]   flags;
        logic [3:0]   bank_sel;
        logic [11:0]  index_base;
        logic [15:0]  instr;
        logic [11:0]  addr;
        logic [7:0]   operand;
        logic [7:0]   result;
        logic [4:0]   res_flags;
        logic [31:0]  prdata;
        logic         pslverr;
    } state_t;

endpackage

// *** core/sub_flags.sv ***
// Purpose: 8-bit subtractor with arithmetic status flags
// Assumes: Computes minuend - subtrahend, purely combinational
// Notes:   Carry means no borrow
`timescale 1ns/1ps
`default_nettype none
`include "subexec_consts.svh"

module sub_flags (
    input  wire logic [7:0] minuend_i,
    input  wire logic [7:0] subtrahend_i,
    output logic [7:0]      diff_o,
    output logic [4:0]      flags_o
);
    logic [8:0] full;
    logic [4:0] low;

    // ==========================================================
    // Arithmetic
    always_comb begin
        full   = {1'b0, minuend_i} - {1'b0, subtrahend_i};
        low    = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]};
        diff_o = full[7:0];
        flags_o                = 5'h00;
        flags_o[`FLAG_C_BIT]   = ~full[8];                            // see RL7
        flags_o[`FLAG_DC_BIT]  = ~low[4];                             // see RL6
        flags_o[`FLAG_Z_BIT]   = (full[7:0] == 8'h00);                // see RL6
        flags_o[`FLAG_OV_BIT]  = (minuend_i[7] != subtrahend_i[7])
                                 && (full[7] != minuend_i[7]);        // see RL6
        flags_o[`FLAG_N_BIT]   = full[7];                             // see RL7
    end

endmodule
`default_nettype wire

// *** verif/subtract_literal_and_file_exec_bench.sv ***
// Purpose: Self-checking bench for the subtract datapath over APB
// Assumes: Zero wait states, ce_i high except in the clock enable test, data memory window at 0x4000
// Notes:   Expected values are worked out here from the flag rules
`timescale 1ns/1ps
`default_nettype none
`include "subexec_consts.svh"

module subtract_literal_and_file_exec_bench;
    // ==========================================================
    // Stimulus and observation
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy_o;
    logic [31:0] last_rd;
    logic        last_err;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;

    always #50 clk_i = ~clk_i;

    subexec_core i_subexec_core (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .busy_o  (busy_o)
    );

    // ==========================================================
    // Reporting
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Generous ceiling; the whole run needs a few hundred cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end

    // ==========================================================
    // APB master
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // Ends on the first edge that sees pready high, else at the bench timeout
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        last_rd  = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check("write_err", {31'h0, last_err}, 32'h0);
    endtask

    function automatic logic [15:0] mem(input logic [11:0] a);
        return 16'h4000 + {2'h0, a, 2'h0};
    endfunction

    // Result in [7:0], flags C DC Z OV N in [12:8]
    function automatic logic [12:0] sub_exp(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        logic [4:0] f;
        d = a - b;
        f[0] = a >= b;
        f[1] = a[3:0] >= b[3:0];
        f[2] = d == 8'h00;
        f[3] = (a[7] ^ b[7]) & (d[7] ^ a[7]);
        f[4] = d[7];
        return {f, d};
    endfunction

    // Issue one instruction and count the busy cycles
    task automatic run_instr(input logic [15:0] ins);
        int n;
        wr(`OFS_INSTR, {16'h0, ins});
        #1;
        n = 0;
        while (busy_o === 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
            #1;
        end
        check("busy_cycles", n, 4);
    endtask

    task automatic file_case(input logic a, input logic d, input logic [7:0] f,
                             input logic [11:0] ea, input logic [7:0] fv, input logic [7:0] wv);
        logic [12:0] e;
        e = sub_exp(fv, wv);
        wr(mem(ea), {24'h0, fv});
        wr(`OFS_WREG, {24'h0, wv});
        run_instr({`OPC_FILE, d, a, f});
        apb(1'b0, `OFS_WREG, 32'h0);
        check("file_w", last_rd, {24'h0, d ? wv : e[7:0]});
        apb(1'b0, mem(ea), 32'h0);
        check("file_mem", last_rd, {24'h0, d ? e[7:0] : fv});
        apb(1'b0, `OFS_STATUS, 32'h0);
        check("file_flags", last_rd, {27'h0, e[12:8]});
    endtask

    // ==========================================================
    // Test sequence
    logic [15:0] ofs [6] = '{`OFS_CTRL, `OFS_WREG, `OFS_STATUS,
                             `OFS_BANK_SEL, `OFS_INDEX_BASE, `OFS_INSTR};
    logic [7:0]  imm_k [5] = '{8'h02, 8'h02, 8'h02, 8'h80, 8'h10};
    logic [7:0]  imm_w [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h01};
    logic [12:0] e;

    initial begin
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("reset_prdata", prdata, 32'h0);
        check("reset_outputs", {29'h0, pready, pslverr, busy_o}, 32'h4);
        rst_n_i <= 1'b1;
        foreach (ofs[i]) begin
            apb(1'b0, ofs[i], 32'h0);
            check("reset_value", last_rd, 32'h0);
        end
        apb(1'b0, 16'h0100, 32'h0);
        check("unmapped_err", {31'h0, last_err}, 32'h1);
        // Immediate subtract: positive, zero, negative, overflow, nibble borrow
        foreach (imm_k[i]) begin
            e = sub_exp(imm_k[i], imm_w[i]);
            wr(`OFS_WREG, {24'h0, imm_w[i]});
            run_instr({`OPC_IMM, imm_k[i]});
            apb(1'b0, `OFS_WREG, 32'h0);
            check("imm_w", last_rd, {24'h0, e[7:0]});
            apb(1'b0, `OFS_STATUS, 32'h0);
            check("imm_flags", last_rd, {27'h0, e[12:8]});
        end
        // File subtract across addressing modes
        wr(`OFS_BANK_SEL, 32'h2);
        file_case(1'b1, 1'b1, 8'h10, 12'h210, 8'h03, 8'h02);
        file_case(1'b0, 1'b0, 8'h20, 12'h020, 8'h02, 8'h02);
        file_case(1'b0, 1'b1, 8'h70, 12'hF70, 8'h01, 8'h02);
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_INDEX_BASE, 32'h300);
        file_case(1'b0, 1'b1, 8'h5F, 12'h35F, 8'h90, 8'h20);
        file_case(1'b0, 1'b0, 8'h60, 12'hF60, 8'h7F, 8'h80);
        file_case(1'b1, 1'b1, 8'h20, 12'h220, 8'h45, 8'h17);
        // Refusals: bad encoding, write while busy
        apb(1'b1, `OFS_INSTR, 32'h0000FFFF);
        check("bad_instr_err", {31'h0, last_err}, 32'h1);
        #1;
        check("bad_instr_busy", {31'h0, busy_o}, 32'h0);
        wr(`OFS_WREG, 32'h05);
        apb(1'b1, `OFS_INSTR, {16'h0, `OPC_IMM, 8'h09});
        apb(1'b1, `OFS_WREG, 32'hAA);
        check("busy_write_err", {31'h0, last_err}, 32'h1);
        repeat (4) @(posedge clk_i);
        apb(1'b0, `OFS_WREG, 32'h0);
        check("busy_write_ignored", last_rd, 32'h04);
        // Clock enable low holds the quarter sequence where it stands
        wr(`OFS_WREG, 32'h03);
        wr(`OFS_INSTR, {16'h0, `OPC_IMM, 8'h07});
        ce_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        ce_i <= 1'b1;
        #1;
        check("frozen_busy", {31'h0, busy_o}, 32'h1);
        repeat (4) @(posedge clk_i);
        #1;
        check("thawed_busy", {31'h0, busy_o}, 32'h0);
        apb(1'b0, `OFS_WREG, 32'h0);
        check("frozen_imm_w", last_rd, 32'h04);
        results();
    end
endmodule
`default_nettype wire
